// ### hw/dsa_pkg.sv
/*
  dsa_pkg: constants, request carriers and region codes for the data-space access unit.
  Assumes a single core clock; every file of the unit imports this package.
*/
package dsa_pkg;

  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 16;
  localparam int          RAM_IDX_W     = 12;
  localparam int          NEAR_W        = 13;
  localparam int          WIN_W         = 15;
  localparam logic [15:0] SFR_LAST      = 16'h07FF;
  localparam logic [15:0] RAM_FIRST     = 16'h0800;
  localparam logic [15:0] RAM_LAST      = 16'h27FF;
  localparam int          WIN_BIT       = 15;
  localparam logic [15:0] STEP_BYTE     = 16'h0001;
  localparam logic [15:0] STEP_WORD     = 16'h0002;
  localparam logic [1:0]  LANE_LO       = 2'h1;
  localparam logic [1:0]  LANE_HI       = 2'h2;
  localparam logic [1:0]  LANE_BOTH     = 2'h3;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  localparam logic [15:0] ZERO_WORD     = 16'h0000;

  // one-hot region codes of an effective address
  typedef enum logic [3:0] {
    DSA_REG_SFR  = 4'h1,
    DSA_REG_RAM  = 4'h2,
    DSA_REG_WIN  = 4'h4,
    DSA_REG_NONE = 4'h8
  } dsa_region_t;

  typedef enum logic [1:0] {
    DSA_XT_LOAD_BYTE = 2'h0,
    DSA_XT_SIGN      = 2'h1,
    DSA_XT_ZERO      = 2'h2,
    DSA_XT_POSTINC   = 2'h3
  } dsa_xt_op_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic        is_byte;
    logic        direct;
    logic        wide;
  } dsa_rd_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [15:0] data;
    logic        is_byte;
    logic        direct;
    logic        wide;
  } dsa_wr_req_t;

  typedef struct packed {
    logic        valid;
    dsa_xt_op_t  op;
    logic [15:0] value;
    logic [7:0]  byte_data;
    logic        is_byte;
  } dsa_xt_req_t;

endpackage : dsa_pkg

// ### hw/dsa_ram.sv
/*
  dsa_ram: word-wide data RAM built as two byte lanes with one shared word index.
  Assumes one read and one write port on the core clock; read data is registered and
  a same-word read and write in one cycle returns the old contents.
*/
module dsa_ram #(
  parameter int IDX_W = 12
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rd_en_in,
  input  wire logic [IDX_W-1:0] rd_idx_in,
  output logic      [15:0]      rd_data_out,
  input  wire logic [1:0]       we_in,
  input  wire logic [IDX_W-1:0] wr_idx_in,
  input  wire logic [15:0]      wr_data_in
);
  import dsa_pkg::*;

  logic [7:0] lane_lo [0:(1<<IDX_W)-1];
  logic [7:0] lane_hi [0:(1<<IDX_W)-1];

  // separate write lines per lane, shared word decode
  always_ff @(posedge ref_clk_in) begin
    if (we_in[0]) begin
      lane_lo[wr_idx_in] <= wr_data_in[7:0];
    end
    if (we_in[1]) begin
      lane_hi[wr_idx_in] <= wr_data_in[15:8];
    end
    if (rd_en_in) begin
      rd_data_out <= {lane_hi[rd_idx_in], lane_lo[rd_idx_in]};
    end
  end

endmodule : dsa_ram

// ### hw/dsa_unit.sv
/*
  dsa_unit: data-space access unit. Decodes byte effective addresses from the read and
  write address generators, serves the on-chip RAM, forwards special-function-register
  and extended-window accesses, steers byte lanes and flags misaligned word accesses.
  Assumes the core presents at most one read and one write request per cycle and that
  register-map and window logic outside answer reads in the cycle after the request.
*/
// Operation
// - every address is a byte address, 64K
// - separate read and write address generators
// - 0000h-7FFFh decode to on-chip space
// - 8000h-FFFFh go to extended window
// - 8K data RAM at 0800h-27FFh
// - low byte even address, high odd
// - post-increment adds one byte, two word
// - byte read selects byte onto low lane
// - shared word decode, per-byte write strobes
// - odd word access raises address error
// - read completes, write suppressed, trap after
// - byte load keeps register high byte
// - sign-extend and zero-extend operations
// - direct field reaches 0000h-1FFFh only
// - wide transfer reaches whole data space
// - 0000h-07FFh is register space
// - unimplemented register reads return zero
module dsa_unit #(
  parameter int RAM_IDX = 12
) (
  input  wire logic                ref_clk_in,
  input  wire logic                rst_in,
  input  wire dsa_pkg::dsa_rd_req_t rd_req_in,
  input  wire dsa_pkg::dsa_wr_req_t wr_req_in,
  output logic                     rd_valid_out,
  output logic [15:0]              rd_data_out,
  output logic                     addr_err_out,
  output logic                     sfr_rd_out,
  output logic [15:0]              sfr_rd_addr_out,
  input  wire logic [15:0]         sfr_rdata_in,
  input  wire logic                sfr_hit_in,
  output logic [1:0]               sfr_we_out,
  output logic [15:0]              sfr_wr_addr_out,
  output logic [15:0]              sfr_wdata_out,
  output logic                     win_rd_out,
  output logic [14:0]              win_rd_addr_out,
  input  wire logic [15:0]         win_rdata_in,
  output logic [1:0]               win_we_out,
  output logic [14:0]              win_wr_addr_out,
  output logic [15:0]              win_wdata_out,
  input  wire dsa_pkg::dsa_xt_req_t xt_req_in,
  output logic                     xt_valid_out,
  output logic [15:0]              xt_result_out
);
  import dsa_pkg::*;

  typedef struct packed {
    logic        rd_p1;
    dsa_region_t rd_reg1;
    logic        rd_hi1;
    logic        rd_byte1;
    logic        rd_bad1;
    logic        rd_v;
    logic [15:0] rd_data;
    logic        trap;
    logic        sfr_rd;
    logic [15:0] sfr_rd_addr;
    logic [1:0]  sfr_we;
    logic [15:0] sfr_wr_addr;
    logic [15:0] wdata;
    logic        win_rd;
    logic [14:0] win_rd_addr;
    logic [1:0]  win_we;
    logic [14:0] win_wr_addr;
    logic        xt_v;
    logic [15:0] xt_res;
  } dsa_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // address helpers

  // near direct field is only 13 bits; wide transfer carries all 16
  function automatic logic [15:0] form_ea(input logic [15:0] a, input logic direct,
                                          input logic wide);
    form_ea = (direct && !wide) ? {3'h0, a[NEAR_W-1:0]} : a;
  endfunction : form_ea

  function automatic dsa_region_t region_of(input logic [15:0] ea);
    if (ea[WIN_BIT]) begin
      region_of = DSA_REG_WIN;
    end else if (ea <= SFR_LAST) begin
      region_of = DSA_REG_SFR;
    end else if (ea <= RAM_LAST) begin
      region_of = DSA_REG_RAM;
    end else begin
      region_of = DSA_REG_NONE;
    end
  endfunction : region_of

  function automatic logic [RAM_IDX-1:0] ram_index(input logic [15:0] ea);
    logic [15:0] off;
    off = ea - RAM_FIRST;
    ram_index = off[RAM_IDX:1];
  endfunction : ram_index

  // lane strobes: bit0 is the even (low) byte
  function automatic logic [1:0] lanes(input logic [15:0] ea, input logic is_byte);
    if (!is_byte) begin
      lanes = LANE_BOTH;
    end else begin
      lanes = ea[0] ? LANE_HI : LANE_LO;
    end
  endfunction : lanes

  ////////////////////////////////////////////////////////////////////////////////
  // request decode, cycle 0

  dsa_state_t       st;
  dsa_state_t       next_st;
  logic [15:0]      rd_ea;
  logic [15:0]      wr_ea;
  dsa_region_t      rd_reg;
  dsa_region_t      wr_reg;
  logic             rd_bad;
  logic             wr_bad;
  logic [1:0]       wr_lanes;
  logic [15:0]      wr_steer;
  logic [1:0]       ram_we;
  logic [15:0]      ram_q;
  logic [15:0]      word1;

  assign rd_ea    = form_ea(rd_req_in.addr, rd_req_in.direct, rd_req_in.wide);
  assign wr_ea    = form_ea(wr_req_in.addr, wr_req_in.direct, wr_req_in.wide);
  assign rd_reg   = region_of(rd_ea);
  assign wr_reg   = region_of(wr_ea);
  // only word accesses care about alignment
  assign rd_bad   = rd_req_in.valid && !rd_req_in.is_byte && rd_ea[0];
  assign wr_bad   = wr_req_in.valid && !wr_req_in.is_byte && wr_ea[0];
  assign wr_lanes = lanes(wr_ea, wr_req_in.is_byte);
  // a byte arrives on the low lane; copy it to both so either strobe finds it
  assign wr_steer = wr_req_in.is_byte ? {wr_req_in.data[7:0], wr_req_in.data[7:0]}
                                      : wr_req_in.data;
  // misaligned write executes but never lands
  assign ram_we   = (wr_req_in.valid && !wr_bad && wr_reg == DSA_REG_RAM) ? wr_lanes
                                                                         : 2'h0;

  dsa_ram #(
    .IDX_W (RAM_IDX)
  ) u_ram (
    .ref_clk_in  (ref_clk_in),
    .rd_en_in    (rd_req_in.valid && rd_reg == DSA_REG_RAM),
    .rd_idx_in   (ram_index(rd_ea)),
    .rd_data_out (ram_q),
    .we_in       (ram_we),
    .wr_idx_in   (ram_index(wr_ea)),
    .wr_data_in  (wr_steer)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st          = st;
    word1            = ZERO_WORD;
    // cycle 0 -> 1: read issue
    next_st.rd_p1    = rd_req_in.valid;
    next_st.rd_reg1  = rd_reg;
    next_st.rd_hi1   = rd_ea[0];
    next_st.rd_byte1 = rd_req_in.is_byte;
    next_st.rd_bad1  = rd_bad;
    next_st.sfr_rd   = rd_req_in.valid && rd_reg == DSA_REG_SFR;
    next_st.win_rd   = rd_req_in.valid && rd_reg == DSA_REG_WIN;
    if (rd_req_in.valid) begin
      // word fetch of the containing word even for odd addresses
      next_st.sfr_rd_addr = {rd_ea[15:1], 1'b0};
      next_st.win_rd_addr = {rd_ea[14:1], 1'b0};
    end
    // cycle 0 -> 1: register and window writes, suppressed when misaligned
    next_st.sfr_we = (wr_req_in.valid && !wr_bad && wr_reg == DSA_REG_SFR) ? wr_lanes
                                                                         : 2'h0;
    next_st.win_we = (wr_req_in.valid && !wr_bad && wr_reg == DSA_REG_WIN) ? wr_lanes
                                                                         : 2'h0;
    if (wr_req_in.valid) begin
      next_st.sfr_wr_addr = {wr_ea[15:1], 1'b0};
      next_st.win_wr_addr = {wr_ea[14:1], 1'b0};
      next_st.wdata       = wr_steer;
    end
    // cycle 1 -> 2: gather read data; missing registers and holes read zero
    unique case (st.rd_reg1)
      DSA_REG_RAM:  word1 = ram_q;
      DSA_REG_SFR:  word1 = sfr_hit_in ? sfr_rdata_in : ZERO_WORD;
      DSA_REG_WIN:  word1 = win_rdata_in;
      DSA_REG_NONE: word1 = ZERO_WORD;
      default:      word1 = ZERO_WORD;
    endcase
    next_st.rd_v = st.rd_p1;
    if (st.rd_p1) begin
      if (st.rd_byte1) begin
        next_st.rd_data = {ZERO_BYTE, st.rd_hi1 ? word1[15:8] : word1[7:0]};
      end else begin
        next_st.rd_data = word1;
      end
    end
    // read trap follows the completed read; write trap follows the dropped write
    next_st.trap = (st.rd_p1 && st.rd_bad1) || wr_bad;
    // working-register data operations
    next_st.xt_v = xt_req_in.valid;
    if (xt_req_in.valid) begin
      unique case (xt_req_in.op)
        DSA_XT_LOAD_BYTE: next_st.xt_res = {xt_req_in.value[15:8],
                                            xt_req_in.byte_data};
        DSA_XT_SIGN:      next_st.xt_res = {{8{xt_req_in.value[7]}},
                                            xt_req_in.value[7:0]};
        DSA_XT_ZERO:      next_st.xt_res = {ZERO_BYTE, xt_req_in.value[7:0]};
        DSA_XT_POSTINC:   next_st.xt_res = xt_req_in.value + (xt_req_in.is_byte ? STEP_BYTE
                                                                             : STEP_WORD);
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      st         <= '0;
      st.rd_reg1 <= DSA_REG_NONE;
    end else begin
      st <= next_st;
    end
  end

  assign rd_valid_out    = st.rd_v;
  assign rd_data_out     = st.rd_data;
  assign addr_err_out    = st.trap;
  assign sfr_rd_out      = st.sfr_rd;
  assign sfr_rd_addr_out = st.sfr_rd_addr;
  assign sfr_we_out      = st.sfr_we;
  assign sfr_wr_addr_out = st.sfr_wr_addr;
  assign sfr_wdata_out   = st.wdata;
  assign win_rd_out      = st.win_rd;
  assign win_rd_addr_out = st.win_rd_addr;
  assign win_we_out      = st.win_we;
  assign win_wr_addr_out = st.win_wr_addr;
  assign win_wdata_out   = st.wdata;
  assign xt_valid_out    = st.xt_v;
  assign xt_result_out   = st.xt_res;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  property p_rd_latency;
    @(posedge ref_clk_in) disable iff (rst_in)
    rd_req_in.valid |-> ##2 rd_valid_out;
  endproperty
  a_rd_latency: assert property (p_rd_latency) else $error("read not answered in 2");

  property p_odd_word_trap;
    @(posedge ref_clk_in) disable iff (rst_in)
    rd_bad |-> ##2 (addr_err_out && rd_valid_out);
  endproperty
  a_odd_word_trap: assert property (p_odd_word_trap) else $error("odd word read no trap");

  property p_no_spurious_trap;
    @(posedge ref_clk_in) disable iff (rst_in)
    addr_err_out |-> ($past(rd_bad, 2) || $past(wr_bad));
  endproperty
  a_no_spurious_trap: assert property (p_no_spurious_trap) else $error("trap w/o cause");

  property p_bad_write_dropped;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_bad |-> ram_we == 2'h0 ##1 (sfr_we_out == 2'h0 && win_we_out == 2'h0 && addr_err_out);
  endproperty
  a_bad_write_dropped: assert property (p_bad_write_dropped) else $error("bad write landed");

  property p_win_route;
    @(posedge ref_clk_in) disable iff (rst_in)
    (rd_req_in.valid && rd_ea[15]) |-> ##1 (win_rd_out && !sfr_rd_out &&
                                           win_rd_addr_out[14:1] == $past(rd_ea[14:1]));
  endproperty
  a_win_route: assert property (p_win_route) else $error("window read misrouted");

  property p_unimpl_zero;
    @(posedge ref_clk_in) disable iff (rst_in)
    (sfr_rd_out && !sfr_hit_in) |-> ##1 rd_data_out == 16'h0000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("hole read not zero");

  property p_byte_lane;
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_req_in.valid && wr_req_in.is_byte && wr_reg == DSA_REG_SFR)
      |-> ##1 sfr_we_out == ($past(wr_ea[0]) ? 2'h2 : 2'h1);
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("wrong byte strobe");

  property p_byte_read_low;
    @(posedge ref_clk_in) disable iff (rst_in)
    (rd_req_in.valid && rd_req_in.is_byte) |-> ##2 rd_data_out[15:8] == 8'h00;
  endproperty
  a_byte_read_low: assert property (p_byte_read_low) else $error("byte read high lane");

  property p_near_direct;
    @(posedge ref_clk_in) disable iff (rst_in)
    (rd_req_in.valid && rd_req_in.direct && !rd_req_in.wide) |-> ##1 !win_rd_out;
  endproperty
  a_near_direct: assert property (p_near_direct) else $error("near direct escaped");

  property p_postinc;
    @(posedge ref_clk_in) disable iff (rst_in)
    (xt_req_in.valid && xt_req_in.op == DSA_XT_POSTINC)
      |=> xt_result_out - $past(xt_req_in.value) == ($past(xt_req_in.is_byte) ? 16'h0001
                                                                          : 16'h0002);
  endproperty
  a_postinc: assert property (p_postinc) else $error("bad pointer step");

  property p_sign_ext;
    @(posedge ref_clk_in) disable iff (rst_in)
    (xt_req_in.valid && xt_req_in.op == DSA_XT_SIGN)
      |=> xt_result_out[15:8] == {8{$past(xt_req_in.value[7])}};
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("sign extend wrong");

  c_byte_write: cover property (@(posedge ref_clk_in) disable iff (rst_in)
                                wr_req_in.valid && wr_req_in.is_byte && ram_we != 2'h0);
  c_odd_trap:   cover property (@(posedge ref_clk_in) disable iff (rst_in) rd_bad ##2 addr_err_out);
  c_win_read:   cover property (@(posedge ref_clk_in) disable iff (rst_in) win_rd_out ##1 rd_valid_out);

endmodule : dsa_unit

// ### verif/dsa_far_model.sv
/*
  dsa_far_model: register-map and extended-window responder beside the access unit.
  Assumes registered lane strobes from the unit; read data is answered in the same cycle.
*/
module dsa_far_model (
  input  wire logic        ref_clk_in,
  input  wire logic        sfr_rd_in,
  input  wire logic [15:0] sfr_rd_addr_in,
  output logic      [15:0] sfr_rdata_out,
  output logic             sfr_hit_out,
  input  wire logic [1:0]  sfr_we_in,
  input  wire logic [15:0] sfr_wr_addr_in,
  input  wire logic [15:0] sfr_wdata_in,
  input  wire logic        win_rd_in,
  input  wire logic [14:0] win_rd_addr_in,
  output logic      [15:0] win_rdata_out,
  input  wire logic [1:0]  win_we_in,
  input  wire logic [14:0] win_wr_addr_in,
  input  wire logic [15:0] win_wdata_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  mem [0:65535];
  logic [15:0] junk;
  // one page of register space has nothing behind it
  function automatic logic implemented(input logic [15:0] a);
    return a[15:8] != 8'h07;
  endfunction : implemented
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
    junk = 16'hA5C3;
  end
  always @(posedge ref_clk_in) begin
    // idle data lines toggle so a stale value never passes for an answer
    junk <= ~{junk[14:0], junk[15]};
    if (implemented(sfr_wr_addr_in)) begin
      if (sfr_we_in[0]) mem[{sfr_wr_addr_in[15:1], 1'b0}] <= sfr_wdata_in[7:0];
      if (sfr_we_in[1]) mem[{sfr_wr_addr_in[15:1], 1'b1}] <= sfr_wdata_in[15:8];
    end
    if (win_we_in[0]) mem[{1'b1, win_wr_addr_in[14:1], 1'b0}] <= win_wdata_in[7:0];
    if (win_we_in[1]) mem[{1'b1, win_wr_addr_in[14:1], 1'b1}] <= win_wdata_in[15:8];
  end
  always_comb begin
    sfr_hit_out   = sfr_rd_in && implemented(sfr_rd_addr_in);
    sfr_rdata_out = sfr_hit_out ? {mem[{sfr_rd_addr_in[15:1], 1'b1}],
                                   mem[{sfr_rd_addr_in[15:1], 1'b0}]} : junk;
    win_rdata_out = win_rd_in ? {mem[{1'b1, win_rd_addr_in[14:1], 1'b1}],
                                 mem[{1'b1, win_rd_addr_in[14:1], 1'b0}]} : ~junk;
  end
endmodule : dsa_far_model

// ### verif/tb_top.sv
/*
  tb_top: random traffic on read, write and extend ports, checked against a byte-array model.
  Assumes the unit's hand-over timing and the far model's register page layout.
*/
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  $display("wrong value %s exp %h got %h", nm, e, g); err_total++; end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dsa_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  dsa_rd_req_t rd_req = '0;
  dsa_wr_req_t wr_req = '0;
  dsa_xt_req_t xt_req = '0;
  logic rd_valid_out, addr_err_out, sfr_rd_out, sfr_hit_in, win_rd_out, xt_valid_out;
  logic [15:0] rd_data_out, sfr_rd_addr_out, sfr_rdata_in, sfr_wr_addr_out, sfr_wdata_out;
  logic [15:0] win_rdata_in, win_wdata_out, xt_result_out;
  logic [14:0] win_rd_addr_out, win_wr_addr_out;
  logic [1:0]  sfr_we_out, win_we_out;
  int err_total = 0;
  int tests_run = 0;
  int wd = 0;
  logic [31:0] seed = 32'hF6E6F344;
  logic [7:0]  mdl [0:65535];
  logic        exp_rdv [0:7], exp_err [0:7], exp_xv [0:7], exp_srd [0:7], exp_wrd [0:7];
  logic [1:0]  exp_swe [0:7], exp_wwe [0:7];
  logic [15:0] exp_sadr [0:7], exp_wdat [0:7], exp_xr [0:7], exp_radr [0:7];
  logic [14:0] exp_wadr [0:7];
  logic [15:0] rdq [$];
  // pools cover register hit and miss pages, both RAM ends, the gap and the window
  logic [15:0] bases [0:7] = '{16'h0400, 16'h0700, 16'h0800, 16'h1FE0,
                               16'h27E0, 16'h2800, 16'h8000, 16'hFFE0};

  always #5 ref_clk_in = ~ref_clk_in;

  dsa_unit #(.RAM_IDX(12)) dut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .rd_req_in(rd_req), .wr_req_in(wr_req),
    .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out), .addr_err_out(addr_err_out),
    .sfr_rd_out(sfr_rd_out), .sfr_rd_addr_out(sfr_rd_addr_out), .sfr_rdata_in(sfr_rdata_in),
    .sfr_hit_in(sfr_hit_in), .sfr_we_out(sfr_we_out), .sfr_wr_addr_out(sfr_wr_addr_out),
    .sfr_wdata_out(sfr_wdata_out), .win_rd_out(win_rd_out), .win_rd_addr_out(win_rd_addr_out),
    .win_rdata_in(win_rdata_in), .win_we_out(win_we_out), .win_wr_addr_out(win_wr_addr_out),
    .win_wdata_out(win_wdata_out), .xt_req_in(xt_req), .xt_valid_out(xt_valid_out),
    .xt_result_out(xt_result_out));

  dsa_far_model far (
    .ref_clk_in(ref_clk_in), .sfr_rd_in(sfr_rd_out), .sfr_rd_addr_in(sfr_rd_addr_out),
    .sfr_rdata_out(sfr_rdata_in), .sfr_hit_out(sfr_hit_in), .sfr_we_in(sfr_we_out),
    .sfr_wr_addr_in(sfr_wr_addr_out), .sfr_wdata_in(sfr_wdata_out), .win_rd_in(win_rd_out),
    .win_rd_addr_in(win_rd_addr_out), .win_rdata_out(win_rdata_in), .win_we_in(win_we_out),
    .win_wr_addr_in(win_wr_addr_out), .win_wdata_in(win_wdata_out));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [15:0] eff(input logic [15:0] a, input logic d, input logic w);
    return (d && !w) ? {3'h0, a[12:0]} : a;
  endfunction : eff

  task automatic finish_test();
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  // reference model: the read is judged before the same cycle's write lands
  task automatic model(input dsa_rd_req_t r, input dsa_wr_req_t w, input dsa_xt_req_t x,
                       input int n);
    logic [15:0] ea, v;
    logic [1:0]  ln;
    if (r.valid) begin
      ea = eff(r.addr, r.direct, r.wide);
      exp_srd[(n + 1) % 8] = ea < 16'h0800;
      exp_wrd[(n + 1) % 8] = ea[15];
      exp_radr[(n + 1) % 8] = ea & 16'hFFFE;
      v = {mdl[ea | 16'h0001], mdl[ea & 16'hFFFE]};
      if (r.is_byte) v = {8'h00, ea[0] ? v[15:8] : v[7:0]};
      rdq.push_back(v);
      exp_rdv[(n + 2) % 8] = 1'b1;
      if (!r.is_byte && ea[0]) exp_err[(n + 2) % 8] = 1'b1;
    end
    if (w.valid) begin
      ea = eff(w.addr, w.direct, w.wide);
      ln = w.is_byte ? (ea[0] ? LANE_HI : LANE_LO) : LANE_BOTH;
      v = w.is_byte ? {2{w.data[7:0]}} : w.data;
      if (!w.is_byte && ea[0]) begin
        exp_err[(n + 1) % 8] = 1'b1;
      end else if (ea < 16'h2800 || ea[15]) begin
        if (!(ea < 16'h0800 && ea[15:8] == 8'h07)) begin
          if (ln[0]) mdl[ea & 16'hFFFE] = v[7:0];
          if (ln[1]) mdl[ea | 16'h0001] = v[15:8];
        end
        if (ea < 16'h0800) exp_swe[(n + 1) % 8] = ln;
        if (ea[15]) exp_wwe[(n + 1) % 8] = ln;
        exp_sadr[(n + 1) % 8] = ea & 16'hFFFE;
        exp_wadr[(n + 1) % 8] = ea[14:0] & 15'h7FFE;
        exp_wdat[(n + 1) % 8] = v;
      end
    end
    if (x.valid) begin
      exp_xv[(n + 1) % 8] = 1'b1;
      case (x.op)
        DSA_XT_LOAD_BYTE: exp_xr[(n + 1) % 8] = {x.value[15:8], x.byte_data};
        DSA_XT_SIGN:      exp_xr[(n + 1) % 8] = {{8{x.value[7]}}, x.value[7:0]};
        DSA_XT_ZERO:      exp_xr[(n + 1) % 8] = {8'h00, x.value[7:0]};
        default:          exp_xr[(n + 1) % 8] = x.value + (x.is_byte ? STEP_BYTE : STEP_WORD);
      endcase
    end
  endtask : model

  task automatic check(input int m);
    int s;
    logic [15:0] q;
    s = m % 8;
    `CHK("rd_valid", exp_rdv[s], rd_valid_out)
    if (exp_rdv[s] && rdq.size() > 0) begin
      // pop once: the macro names its expected value twice
      q = rdq.pop_front();
      `CHK("rd_data", q, rd_data_out)
    end
    `CHK("addr_err", exp_err[s], addr_err_out)
    `CHK("sfr_rd", exp_srd[s], sfr_rd_out)
    `CHK("win_rd", exp_wrd[s], win_rd_out)
    if (exp_srd[s]) `CHK("sfr_rd_addr", exp_radr[s], sfr_rd_addr_out)
    if (exp_wrd[s]) `CHK("win_rd_addr", exp_radr[s][14:0], win_rd_addr_out)
    `CHK("sfr_we", exp_swe[s], sfr_we_out)
    `CHK("win_we", exp_wwe[s], win_we_out)
    if (exp_swe[s] != 2'h0) `CHK("sfr_wr_addr", exp_sadr[s], sfr_wr_addr_out)
    if (exp_swe[s] != 2'h0) `CHK("sfr_wdata", exp_wdat[s], sfr_wdata_out)
    if (exp_wwe[s] != 2'h0) `CHK("win_wr_addr", exp_wadr[s], win_wr_addr_out)
    if (exp_wwe[s] != 2'h0) `CHK("win_wdata", exp_wdat[s], win_wdata_out)
    `CHK("xt_valid", exp_xv[s], xt_valid_out)
    if (exp_xv[s]) `CHK("xt_result", exp_xr[s], xt_result_out)
    exp_rdv[s] = 1'b0;
    exp_err[s] = 1'b0;
    exp_xv[s]  = 1'b0;
    exp_swe[s] = 2'h0;
    exp_wwe[s] = 2'h0;
    exp_srd[s] = 1'b0;
    exp_wrd[s] = 1'b0;
  endtask : check

  always @(posedge ref_clk_in) begin
    wd++;
    if (wd == 20000) begin
      err_total++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    dsa_rd_req_t nr;
    dsa_wr_req_t nw;
    dsa_xt_req_t nx;
    logic [31:0] a, b;
    for (int i = 0; i < 65536; i++) mdl[i] = 8'h00;
    for (int i = 0; i < 8; i++) begin
      exp_rdv[i] = 1'b0;
      exp_err[i] = 1'b0;
      exp_xv[i] = 1'b0;
      exp_swe[i] = 2'h0;
      exp_wwe[i] = 2'h0;
      exp_srd[i] = 1'b0;
      exp_wrd[i] = 1'b0;
    end
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    #1;
    `CHK("rd_valid_reset", 1'b0, rd_valid_out)
    // first fill every pool word so RAM is never read unwritten, then random mix
    for (int c = 0; c < 4136; c++) begin
      @(posedge ref_clk_in);
      a = xs();
      b = xs();
      nr = '0;
      nw = '0;
      nx = '0;
      if (c < 128) begin
        nw = '{1'b1, bases[c / 16] + 16'(2 * (c % 16)), a[31:16], 1'b0, 1'b0, 1'b0};
      end else if (c < 4128) begin
        nr = '{a[12] | a[13], bases[a[2:0]] + 16'(a[7:3]), a[11], a[8] & a[9], a[10]};
        nw = '{b[12] | b[13], bases[b[2:0]] + 16'(b[7:3]), a[31:16], b[11], b[8] & b[9], b[10]};
        nx = '{b[14], dsa_xt_op_t'(b[16:15]), b[31:16], a[27:20], a[28]};
      end
      rd_req <= nr;
      wr_req <= nw;
      xt_req <= nx;
      model(nr, nw, nx, c);
      #1;
      check(c);
    end
    `CHK("reads_left", 0, rdq.size())
    finish_test();
  end
endmodule : tb_top
